// ==== design/nsec_status_ecc.sv ====
// Purpose: status byte, write latch, failure flags and correction control
// Assumes: link clock stops between frames; cs_n high while rst_i is high
// Notes: array sequencing and the correction engine are outside this block
`timescale 1ns/1ns
module nsec_status_ecc (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  input wire logic block_locked_i,
  input wire nsec_pkg::nsec_array_rsp_s array_rsp_i,
  output nsec_pkg::nsec_array_cmd_s array_cmd_o
);
  import nsec_pkg::*;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [5:0] cmd_len(input logic [7:0] opc);
    logic [5:0] n;
    n = LEN_NONE;
    case (opc)
      OP_WREN, OP_WRDI, OP_RESET: n = LEN_SHORT;
      OP_SETF: n = LEN_SETF;
      OP_PREAD, OP_PEXEC, OP_BERASE: n = LEN_ADDR;
      default: n = LEN_NONE;
    endcase
    return n;
  endfunction

  // worst segment decides the page outcome
  function automatic logic [1:0] ecc_grade(input logic [SEG_COUNT-1:0][3:0] errs);
    logic [1:0] g;
    g = ECC_NONE;
    for (int i = 0; i < SEG_COUNT; i++) begin
      if (errs[i] > ECC_MAX_FIX) begin
        g = ECC_FAIL;
      end else if (errs[i] != 4'h0 && g == ECC_NONE) begin
        g = ECC_FIXED;
      end
    end
    return g;
  endfunction

  // ---------------------------------------------------------------
  // link side: command shifter
  // ---------------------------------------------------------------
  logic [5:0] bit_cnt_q;
  logic [31:0] sh_q;
  logic [7:0] op_q;
  logic [7:0] faddr_q;
  nsec_link_cmd_s lcmd_q;
  logic tog_q;
  logic [7:0] stat_s1_q;
  logic [7:0] stat_s2_q;
  logic [7:0] cfg_s1_q;
  logic [7:0] cfg_s2_q;
  logic [7:0] out_sh_q;
  logic so_q;
  logic so_oe_q;
  // core-side registers, declared early since the link syncs read them
  logic [7:0] cfg_q;
  logic [7:0] status_q;

  wire [31:0] sh_d = {sh_q[30:0], si_i};
  wire [5:0] cnt_inc = (bit_cnt_q == BIT_SAT) ? bit_cnt_q : bit_cnt_q + 6'h01;
  wire [7:0] cur_op = (bit_cnt_q == BIT_OP_LAST) ? sh_d[7:0] : op_q;
  wire [5:0] cur_len = cmd_len(cur_op);
  wire frame_done = (cur_len != LEN_NONE) && (bit_cnt_q != BIT_SAT) && (cnt_inc == cur_len);
  wire [7:0] rd_byte = (faddr_q == FA_STAT) ? stat_s2_q :
                       (faddr_q == FA_CFG) ? cfg_s2_q : 8'h00;
  wire load_out = (op_q == OP_GETF) && (bit_cnt_q >= BIT_DATA_FIRST) &&
                  (bit_cnt_q[2:0] == 3'h0) && (bit_cnt_q != BIT_SAT);

  // frame state ends with cs_n, since the link clock stops outside frames
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_cnt_q <= 6'h00;
      sh_q <= 32'h0000_0000;
      op_q <= 8'h00;
      faddr_q <= 8'h00;
    end else begin
      bit_cnt_q <= cnt_inc;
      sh_q <= sh_d;
      op_q <= cur_op;
      if (bit_cnt_q == BIT_FA_LAST) begin
        faddr_q <= sh_d[7:0];
      end
    end
  end

  // command word is held stable until the next frame ends
  always_ff @(posedge sck_i or posedge rst_i) begin
    if (rst_i) begin
      tog_q <= 1'b0;
      lcmd_q <= '0;
    end else if (frame_done) begin
      tog_q <= ~tog_q;
      lcmd_q <= '{opcode: cur_op, arg: sh_d[23:0]};
    end
  end

  // status levels into the link domain; bits may skew by one link edge
  always_ff @(posedge sck_i or posedge rst_i) begin
    if (rst_i) begin
      stat_s1_q <= 8'h00;
      stat_s2_q <= 8'h00;
      cfg_s1_q <= CFG_RESET;
      cfg_s2_q <= CFG_RESET;
    end else begin
      stat_s1_q <= status_q;
      stat_s2_q <= stat_s1_q;
      cfg_s1_q <= cfg_q;
      cfg_s2_q <= cfg_s1_q;
    end
  end

  // data out on the falling edge so the host samples it on the rising one
  always_ff @(negedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
      out_sh_q <= 8'h00;
    end else if (load_out) begin
      so_q <= rd_byte[7];
      so_oe_q <= 1'b1;
      out_sh_q <= {rd_byte[6:0], 1'b0};
    end else begin
      so_q <= out_sh_q[7];
      out_sh_q <= {out_sh_q[6:0], 1'b0};
    end
  end

  assign so_o = so_q;
  assign so_oe_o = so_oe_q;

  // ---------------------------------------------------------------
  // core side: command take-over
  // ---------------------------------------------------------------
  logic tog_s1_q;
  logic tog_s2_q;
  logic tog_s3_q;
  nsec_state_e state_q;
  nsec_state_e state_d;
  nsec_aop_e op_cur_q;
  nsec_aop_e op_cur_d;
  logic start_d;
  logic wel_q;
  logic efail_q;
  logic pfail_q;
  logic [1:0] ecc_q;
  nsec_array_cmd_s array_cmd_q;

  // one pulse per completed command frame, none for get-features; lcmd_q has long settled by then
  wire take = tog_s2_q ^ tog_s3_q;
  wire [7:0] opc = lcmd_q.opcode;
  wire idle = (state_q == ST_IDLE);
  wire busy = (state_q != ST_IDLE);
  wire do_wren = take && idle && opc == OP_WREN;
  wire do_wrdi = take && idle && opc == OP_WRDI;
  wire do_setf = take && idle && opc == OP_SETF && lcmd_q.arg[15:8] == FA_CFG;
  wire do_reset = take && opc == OP_RESET;
  wire do_read = take && idle && opc == OP_PREAD;
  wire do_prog = take && idle && opc == OP_PEXEC && wel_q;
  wire do_erase = take && idle && opc == OP_BERASE && wel_q;
  // locked targets fail at once, the array is never started
  wire lock_prog = do_prog && block_locked_i;
  wire lock_erase = do_erase && block_locked_i;
  wire issue = do_read || (do_prog && !block_locked_i) || (do_erase && !block_locked_i);
  wire op_done = (state_q == ST_BUSY) && array_rsp_i.done;
  wire done_read = op_done && op_cur_q == AOP_READ;
  wire done_prog = op_done && op_cur_q == AOP_PROG;
  wire done_erase = op_done && op_cur_q == AOP_ERASE;
  wire [1:0] grade = ecc_grade(array_rsp_i.seg_errs);
  wire [15:0] row_d = (state_q == ST_BOOT) ? 16'h0000 : lcmd_q.arg[15:0];

  // two flops to settle, the third only for edge detection
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
    end else begin
      tog_s1_q <= tog_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
    end
  end

  // ---------------------------------------------------------------
  // core side: operation sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    op_cur_d = op_cur_q;
    start_d = 1'b0;
    case (state_q)
      ST_BOOT: begin
        state_d = ST_BUSY;
        op_cur_d = AOP_READ;
        start_d = 1'b1;
      end
      ST_IDLE: begin
        if (issue) begin
          state_d = ST_BUSY;
          start_d = 1'b1;
          op_cur_d = do_read ? AOP_READ : (do_prog ? AOP_PROG : AOP_ERASE);
        end
      end
      ST_BUSY: begin
        if (array_rsp_i.done) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (do_reset) begin
      state_d = ST_BUSY;
      op_cur_d = AOP_RESET;
      start_d = 1'b1;
    end
  end

  // correction setting rides along with every read and program
  wire nsec_array_cmd_s array_cmd_d = '{start: start_d, op: op_cur_d,
    ecc_en: cfg_q[CFG_ECC_BIT], row: row_d};

  // a refused locked request disarms the latch as well
  wire wel_d = do_wren ? 1'b1 :
               (do_wrdi || do_reset || lock_prog || lock_erase ||
                done_prog || done_erase) ? 1'b0 : wel_q;
  // hardware set wins over any clear arriving in the same cycle
  wire efail_d = ((done_erase && array_rsp_i.fail) || lock_erase) ? 1'b1 :
                 (do_reset || do_erase) ? 1'b0 : efail_q;
  wire pfail_d = ((done_prog && array_rsp_i.fail) || lock_prog) ? 1'b1 :
                 (do_reset || do_prog) ? 1'b0 : pfail_q;
  // outcome left at zero when correction is off
  wire [1:0] ecc_d = (do_reset || do_read) ? ECC_NONE :
                     (done_read && cfg_q[CFG_ECC_BIT]) ? grade : ecc_q;
  wire [7:0] cfg_d = do_setf ? lcmd_q.arg[7:0] : cfg_q;
  wire [7:0] status_d = {2'b00, ecc_q, pfail_q, efail_q, wel_q, busy};

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_q <= ST_BOOT;
      op_cur_q <= AOP_READ;
      array_cmd_q <= '0;
      wel_q <= 1'b0;
      efail_q <= 1'b0;
      pfail_q <= 1'b0;
      ecc_q <= ECC_NONE;
      cfg_q <= CFG_RESET;
      status_q <= 8'h00;
    end else begin
      state_q <= state_d;
      op_cur_q <= op_cur_d;
      array_cmd_q <= array_cmd_d;
      wel_q <= wel_d;
      efail_q <= efail_d;
      pfail_q <= pfail_d;
      ecc_q <= ecc_d;
      cfg_q <= cfg_d;
      status_q <= status_d;
    end
  end

  assign array_cmd_o = array_cmd_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_start_sets_busy:
    assert property (@(posedge clock_i) disable iff (rst_i)
      array_cmd_q.start |-> (state_q == ST_BUSY) ##1 status_q[SB_OIP])
    else $error("busy bit not set after operation start");

  a_unarmed_refused:
    assert property (@(posedge clock_i) disable iff (rst_i)
      (take && idle && !wel_q && (opc == OP_PEXEC || opc == OP_BERASE))
      |=> !array_cmd_q.start)
    else $error("program or erase started without armed latch");

  a_wrdi_clears:
    assert property (@(posedge clock_i) disable iff (rst_i)
      do_wrdi |=> !wel_q ##1 !status_q[SB_WEL])
    else $error("write disable left latch armed");

  a_erase_lock_code:
    assert property (@(posedge clock_i) disable iff (rst_i)
      (lock_erase && !do_reset) |=> !array_cmd_q.start ##1 status_q[3:0] == 4'h4)
    else $error("locked erase did not report 04h");

  a_prog_lock_code:
    assert property (@(posedge clock_i) disable iff (rst_i)
      (lock_prog && !do_reset) |=> !array_cmd_q.start ##1 status_q[3:0] == 4'h8)
    else $error("locked program did not report 08h");

  a_erase_flag_clear:
    assert property (@(posedge clock_i) disable iff (rst_i)
      (do_erase && !block_locked_i) |=> !efail_q)
    else $error("erase failure not cleared at erase start");

  a_prog_flag_clear:
    assert property (@(posedge clock_i) disable iff (rst_i)
      (do_prog && !block_locked_i) |=> !pfail_q)
    else $error("program failure not cleared at program start");

  a_read_clears_ecc:
    assert property (@(posedge clock_i) disable iff (rst_i)
      do_read |=> (ecc_q == ECC_NONE) throughout (state_q == ST_BUSY)[*1])
    else $error("outcome not cleared at read start");

  a_ecc_off_quiet:
    assert property (@(posedge clock_i) disable iff (rst_i)
      (done_read && !cfg_q[CFG_ECC_BIT] && !do_reset) |=> ecc_q == $past(ecc_q))
    else $error("outcome changed with correction off");

  a_top_bits_zero:
    assert property (@(posedge clock_i) disable iff (rst_i)
      status_q[7:6] == 2'b00 && status_q[SB_WEL] == $past(wel_q) &&
      status_q[SB_PFAIL] == $past(pfail_q))
    else $error("status byte layout broken");

  a_setf_applies:
    assert property (@(posedge clock_i) disable iff (rst_i)
      do_setf |=> cfg_q == lcmd_q.arg[7:0])
    else $error("feature byte not taken from set-features");

  a_reset_clears:
    assert property (@(posedge clock_i) disable iff (rst_i)
      (do_reset && !op_done) |=> !efail_q && !pfail_q && ecc_q == ECC_NONE)
    else $error("reset command left a flag or outcome set");

  a_boot_read:
    assert property (@(posedge clock_i) disable iff (rst_i)
      $fell(rst_i) |=> array_cmd_q.start && array_cmd_q.op == AOP_READ &&
      array_cmd_q.row == 16'h0000 && array_cmd_q.ecc_en)
    else $error("no power-on read of page 0 with correction on");

endmodule

// ==== inc/nsec_pkg.sv ====
// Purpose: shared constants and types of the status and ECC control block
// Assumes: serial link in mode 0, single data line, opcode first, msb first
// Notes: the array and its correction engine sit outside and answer per op
// What this block does
// - eight-bit status byte readable at any time
// - bit 0 high while operation runs
// - program and erase need armed write latch
// - write disable 04h clears the write latch
// - bit 2 set on erase failure or lock
// - program failure set on failure or lock
// - program failure cleared by reset, program execute
// - bits 5:4 give correction outcome code
// - outcome cleared at read start, updated after
// - after power-on, outcome of page 0 block 0
// - outcome meaningless while correction is off
// - read corrects up to four bits in cache
// - correction enabled after power-up
// - set-features 1Fh, address B0h, bit 4 enables
// - program computes parity over main data first
// - page holds four correction segments plus spares
// - get-features 0Fh reads the status byte
// - locked erase gives 04h, program gives 08h
package nsec_pkg;

  // ---------------------------------------------------------------
  // command set
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_GETF = 8'h0f;
  localparam logic [7:0] OP_SETF = 8'h1f;
  localparam logic [7:0] OP_PREAD = 8'h13;
  localparam logic [7:0] OP_PEXEC = 8'h10;
  localparam logic [7:0] OP_BERASE = 8'hd8;
  localparam logic [7:0] OP_RESET = 8'hff;
  localparam logic [7:0] FA_CFG = 8'hb0;
  localparam logic [7:0] FA_STAT = 8'hc0;

  // frame lengths in link bits
  localparam logic [5:0] LEN_NONE = 6'h00;
  localparam logic [5:0] LEN_SHORT = 6'h08;
  localparam logic [5:0] LEN_SETF = 6'h18;
  localparam logic [5:0] LEN_ADDR = 6'h20;
  localparam logic [5:0] BIT_OP_LAST = 6'h07;
  localparam logic [5:0] BIT_FA_LAST = 6'h0f;
  localparam logic [5:0] BIT_DATA_FIRST = 6'h10;
  localparam logic [5:0] BIT_SAT = 6'h3f;

  // ---------------------------------------------------------------
  // status byte and feature byte layout
  // ---------------------------------------------------------------
  localparam int SB_OIP = 0;
  localparam int SB_WEL = 1;
  localparam int SB_EFAIL = 2;
  localparam int SB_PFAIL = 3;
  localparam int CFG_ECC_BIT = 4;
  localparam logic [7:0] CFG_RESET = 8'h10;
  localparam logic [1:0] ECC_NONE = 2'h0;
  localparam logic [1:0] ECC_FIXED = 2'h1;
  localparam logic [1:0] ECC_FAIL = 2'h2;
  localparam logic [3:0] ECC_MAX_FIX = 4'h4;

  // page layout of the correction segments
  localparam int SEG_COUNT = 4;
  localparam logic [11:0] SEG_MAIN_SIZE = 12'h200;
  localparam logic [11:0] SPARE_BASE = 12'h800;
  localparam logic [11:0] SPARE_STRIDE = 12'h020;
  localparam logic [11:0] SPARE_M1_OFS = 12'h004;
  localparam logic [11:0] SPARE_RSV_OFS = 12'h008;
  localparam logic [11:0] SPARE_END = 12'h83f;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    AOP_READ = 2'b00, AOP_PROG = 2'b01, AOP_ERASE = 2'b10, AOP_RESET = 2'b11
  } nsec_aop_e;

  typedef enum logic [1:0] {
    ST_BOOT = 2'b00, ST_IDLE = 2'b01, ST_BUSY = 2'b10
  } nsec_state_e;

  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] arg;
  } nsec_link_cmd_s;

  typedef struct packed {
    logic start;
    nsec_aop_e op;
    logic ecc_en;
    logic [15:0] row;
  } nsec_array_cmd_s;

  typedef struct packed {
    logic done;
    logic fail;
    logic [SEG_COUNT-1:0][3:0] seg_errs;
  } nsec_array_rsp_s;

endpackage

// ==== verif/nsec_array_model.sv ====
// Purpose: behavioural array and correction engine facing the status block
// Assumes: one operation at a time; a new start restarts the count
// Notes: fail and seg_errs carry junk outside done, as the real engine may
`timescale 1ns/1ns
module nsec_array_model (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire nsec_pkg::nsec_array_cmd_s cmd_i,
  input wire logic fail_i,
  input wire logic [15:0] errs_i,
  input wire logic [9:0] dly_i,
  output nsec_pkg::nsec_array_rsp_s rsp_o
);
  import nsec_pkg::*;
  logic [9:0] cnt_q;
  logic done_q;

  // ---------------------------------------------------------------
  // busy time and completion
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cnt_q <= 10'h000;
      done_q <= 1'b0;
    end else begin
      done_q <= (cnt_q == 10'h001);
      if (cmd_i.start) begin
        cnt_q <= dly_i;
      end else if (cnt_q != 10'h000) begin
        cnt_q <= cnt_q - 10'h001;
      end
    end
  end

  // inverted values outside done catch a design that samples too early
  assign rsp_o.done = done_q;
  assign rsp_o.fail = done_q ? fail_i : ~fail_i;
  assign rsp_o.seg_errs = done_q ? errs_i : ~errs_i;
endmodule

// ==== verif/testbench.sv ====
// Purpose: host-side command sequences against the status and ECC block
// Assumes: link clock runs only inside frames, 48 ns period
// Notes: status polled with get-features on the status address
`timescale 1ns/1ns
module testbench;
  import nsec_pkg::*;
  localparam logic [15:0] TBL [3] = '{16'h0000, 16'h4040, 16'h5010};
  localparam logic [1:0] OUTC [3] = '{ECC_NONE, ECC_FIXED, ECC_FAIL};
  logic clock_i, so_o, so_oe_o, oe;
  logic rst_i = 1'b1, sck_i = 1'b0, cs_n_i = 1'b1, si_i = 1'b0, locked = 1'b0, fail = 1'b0;
  logic [15:0] errs = 16'h0300;
  logic [9:0] dly = 10'd400;
  logic [7:0] s, q;
  nsec_array_cmd_s acmd;
  nsec_array_rsp_s arsp;
  int err_total, comparisons, starts, k, n0;

  nsec_status_ecc dut_u (.clock_i(clock_i), .rst_i(rst_i), .sck_i(sck_i), .cs_n_i(cs_n_i),
    .si_i(si_i), .so_o(so_o), .so_oe_o(so_oe_o), .block_locked_i(locked),
    .array_rsp_i(arsp), .array_cmd_o(acmd));
  nsec_array_model model_u (.clock_i(clock_i), .rst_i(rst_i), .cmd_i(acmd), .fail_i(fail),
    .errs_i(errs), .dly_i(dly), .rsp_o(arsp));

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) if (acmd.start === 1'b1) starts++;

  // ---------------------------------------------------------------
  // host tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // frame of n bits msb first; r keeps the last 8 bits seen on so_o
  task automatic spi(input logic [31:0] d, input int n, output logic [7:0] r);
    cs_n_i <= 1'b0;
    for (int i = 0; i < n; i++) begin
      si_i <= d[31-i];
      #24 r = {r[6:0], so_o};
      oe = so_oe_o;
      sck_i <= 1'b1;
      #24 sck_i <= 1'b0;
    end
    #24 cs_n_i <= 1'b1;
    repeat (8) @(posedge clock_i);
  endtask
  task automatic feat(input logic [7:0] a, output logic [7:0] v);
    spi({OP_GETF, a, 16'h0000}, 24, v);
    chk({oe, so_oe_o}, 2'b10);
  endtask
  task automatic fchk(input logic [7:0] a, input logic [7:0] e);
    feat(a, s);
    chk(s, e);
  endtask
  task automatic op(input logic [7:0] o);
    spi({o, 24'h000000}, 8, q);
  endtask
  task automatic ready(input logic [7:0] e);
    repeat (100) begin
      feat(FA_STAT, s);
      if (s[0] === 1'b0) break;
    end
    chk(s, e);
  endtask
  task automatic run(input logic [7:0] o, input int n, input logic [15:0] r,
                     input logic [7:0] e);
    spi({o, 8'h00, r}, n, q);
    ready(e);
  endtask
  task automatic arun(input logic [7:0] o, input logic [15:0] r, input logic [7:0] e);
    op(OP_WREN);
    run(o, 32, r, e);
  endtask
  task automatic setp(input logic f, input logic [15:0] e, input logic [9:0] d,
                      input logic l);
    @(posedge clock_i);
    fail <= f;
    errs <= e;
    dly <= d;
    locked <= l;
  endtask
  task automatic tally_and_finish;
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #300000;
    err_total++;
    tally_and_finish;
  end

  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    chk(starts, 1);
    chk({acmd.op, acmd.ecc_en, acmd.row}, {AOP_READ, 1'b1, 16'h0000});
    fchk(FA_STAT, 8'h01);
    ready(8'h10);
    fchk(FA_CFG, CFG_RESET);
    fchk(8'ha0, 8'h00);
    for (k = 0; k < 3; k++) begin
      setp(1'b0, TBL[k], 10'd20, 1'b0);
      run(OP_PREAD, 32, 16'(k + 5), {2'b00, OUTC[k], 4'h0});
      chk(acmd.row, k + 5);
    end
    // slow read: outcome must clear at its start
    setp(1'b0, 16'h0000, 10'd300, 1'b0);
    spi({OP_PREAD, 24'h000009}, 32, q);
    fchk(FA_STAT, 8'h01);
    ready(8'h00);
    run(OP_WREN, 8, 16'h0, 8'h02);
    run(OP_WRDI, 8, 16'h0, 8'h00);
    n0 = starts;
    run(OP_BERASE, 32, 16'h0040, 8'h00);
    chk(starts, n0);
    setp(1'b1, 16'h0000, 10'd20, 1'b0);
    arun(OP_BERASE, 16'h0040, 8'h04);
    setp(1'b0, 16'h0000, 10'd300, 1'b0);
    op(OP_WREN);
    spi({OP_BERASE, 24'h000040}, 32, q);
    fchk(FA_STAT, 8'h03);
    ready(8'h00);
    setp(1'b1, 16'h0000, 10'd20, 1'b0);
    arun(OP_PEXEC, 16'h0041, 8'h08);
    setp(1'b0, 16'h0000, 10'd20, 1'b0);
    arun(OP_PEXEC, 16'h0041, 8'h00);
    setp(1'b1, 16'h0000, 10'd20, 1'b0);
    arun(OP_PEXEC, 16'h0042, 8'h08);
    arun(OP_BERASE, 16'h0080, 8'h0c);
    setp(1'b0, 16'h0000, 10'd20, 1'b0);
    run(OP_RESET, 8, 16'h0, 8'h00);
    setp(1'b0, 16'h0000, 10'd20, 1'b1);
    n0 = starts;
    arun(OP_BERASE, 16'h00c0, 8'h04);
    chk(starts, n0);
    run(OP_RESET, 8, 16'h0, 8'h00);
    arun(OP_PEXEC, 16'h00c1, 8'h08);
    setp(1'b0, 16'h0000, 10'd20, 1'b0);
    run(OP_RESET, 8, 16'h0, 8'h00);
    // correction off, then back on
    spi({OP_SETF, FA_CFG, 8'h00, 8'h00}, 24, q);
    fchk(FA_CFG, 8'h00);
    setp(1'b0, 16'h0020, 10'd20, 1'b0);
    run(OP_PREAD, 32, 16'h0007, 8'h00);
    chk(acmd.ecc_en, 1'b0);
    spi({OP_SETF, FA_CFG, 8'h10, 8'h00}, 24, q);
    fchk(FA_CFG, 8'h10);
    arun(OP_PEXEC, 16'h0007, 8'h00);
    chk({acmd.op, acmd.ecc_en}, {AOP_PROG, 1'b1});
    tally_and_finish;
  end
endmodule
